// [meter_host.sv]
// Metering host model: register access port and converter timing strobes
`timescale 1ns/1ns
`default_nettype none

module meter_host
	import protect_sync_pkg::*;
(
	// Clock
	input  wire logic     mclk,
	// Register access
	input  wire reg_rsp_s rsp,
	output var  reg_req_s req,
	// Converter timing
	output var  logic     sample_strobe,
	output var  logic     output_access
);
	initial begin
		req = '0;
		sample_strobe = 1'b0;
		output_access = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Falling-edge launch keeps the request stable across the taking rising edge
	task automatic access(input logic w, input logic [4:0] a, input logic [7:0] d,
		output logic [15:0] q);
		@(negedge mclk);
		req = '{w, ~w, a, d};
		@(negedge mclk);
		q = rsp.data;
		req = '0;
	endtask

	task automatic timing(input logic s, input logic a);
		@(negedge mclk);
		sample_strobe = s;
		output_access = a;
		@(negedge mclk);
		sample_strobe = 1'b0;
		output_access = 1'b0;
	endtask
endmodule // meter_host

`default_nettype wire

// [protect_sync_pkg.sv]
// Shared offsets, reset values, keys and carrier types for the protect/sync register bank
package protect_sync_pkg;

	localparam logic [4:0]  snapshot_addr      = 5'h07;
	localparam logic [4:0]  status_primary_addr = 5'h09;
	localparam logic [4:0]  protection_key_addr = 5'h0a;
	localparam logic [4:0]  align_capture_addr  = 5'h0b;
	localparam logic [4:0]  pulse_slot_addr     = 5'h0e;
	localparam logic [4:0]  secondary_status_addr = 5'h0f;

	localparam logic [7:0]  lock_key           = 8'hca;
	localparam logic [7:0]  unlock_key         = 8'h9c;
	localparam logic [7:0]  key_read_value     = 8'h00;
	localparam logic [7:0]  pulse_slot_reset   = 8'hff;
	localparam logic [11:0] counter_reset      = 12'h000;
	localparam logic [2:0]  version_default    = 3'h0;

	localparam int          align_bit          = 0;
	localparam int          capture_bit        = 1;
	localparam int          protected_bit      = 2;
	localparam int          missed_bit         = 3;

	localparam logic [1:0]  slot_div_last      = 2'h3;
	localparam int          key_write_cycles   = 1;

	typedef struct packed {
		logic       wr_en;
		logic       rd_en;
		logic [4:0] addr;
		logic [7:0] wdata;
	} reg_req_s;

	typedef struct packed {
		logic        valid;
		logic [15:0] data;
	} reg_rsp_s;

endpackage

// [protect_sync_status_regs.sv]
// Protection key, align/capture strobes, pulse slot mask and status registers
`timescale 1ns/1ns
`default_nettype none

// How it works
// R1 - Key 0xca turns write protection on
// R2 - Key 0x9c turns write protection off
// R3 - Key register reads back as zero
// R4 - Host broadcasts align and capture together
// R5 - Align bit fires align pulse immediately
// R6 - Capture bit latches counter on write
// R7 - Align and capture bits self-clear next cycle
// R8 - Mask bit n gates pulse slot n
// R9 - All mask bits reset to one
// R10 - Missed access of outputs sets flag
// R11 - Reading secondary status clears missed flag
// R12 - Version number in status bits 2:0
// R13 - Reserved bits read zero, do nothing
// R14 - Protected flag shows lock state
// R15 - Twelve-bit snapshot readable at its register
// R16 - Locked config ignores writes until unlock
module protect_sync_status_regs
	import protect_sync_pkg::*;
#(
	parameter logic [2:0] version = version_default
)(
	// Clock and reset
	input  wire logic       mclk,
	input  wire logic       rst_n,
	// Register access from the serial front end
	input  wire reg_req_s   req,
	output var  reg_rsp_s   rsp,
	// Converter timing
	input  wire logic       sample_strobe,
	input  wire logic       output_access,
	// Control outputs
	output var  logic       align_pulse,
	output var  logic       capture_pulse,
	output var  logic       config_protected_flag,
	output var  logic       missed_sample_flag,
	output var  logic [7:0] pulse_slot_mask,
	output var  logic       pwm_pulse_en
);

	////////////////////////////////////////////////////////////////////////////////
	// Decode

	function automatic logic hit(input reg_req_s r, input logic [4:0] a);
		return r.addr == a;
	endfunction

	wire wr_key     = req.wr_en && hit(req, protection_key_addr);
	wire wr_align   = req.wr_en && hit(req, align_capture_addr);
	wire wr_mask    = req.wr_en && hit(req, pulse_slot_addr) && !config_protected_flag; // R16
	wire rd_secondary_status = req.rd_en && hit(req, secondary_status_addr);

	logic [11:0] free_counter;
	logic [11:0] captured_counter_value;
	logic        accessed;

	wire  [7:0] secondary_status = {4'h0, missed_sample_flag, version}; // R12 R13
	wire  [7:0] primary_status   = {5'h00, config_protected_flag, 2'h0}; // R14
	wire  [7:0] align_capture    = {6'h00, capture_pulse, align_pulse}; // R13

	wire [15:0] read_mux =
		hit(req, protection_key_addr)   ? {8'h00, key_read_value} : // R3
		hit(req, align_capture_addr)    ? {8'h00, align_capture} :
		hit(req, pulse_slot_addr)       ? {8'h00, pulse_slot_mask} :
		hit(req, secondary_status_addr) ? {8'h00, secondary_status} :
		hit(req, status_primary_addr)   ? {8'h00, primary_status} :
		hit(req, snapshot_addr)         ? {4'h0, captured_counter_value} : // R15
		16'h0000;

	wire missed_event = sample_strobe && !accessed; // R10

	////////////////////////////////////////////////////////////////////////////////
	// Registers

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			config_protected_flag <= 1'b0;
		end else if (wr_key && req.wdata == lock_key) begin
			config_protected_flag <= 1'b1; // R1
		end else if (wr_key && req.wdata == unlock_key) begin
			config_protected_flag <= 1'b0; // R2
		end
	end

	// Strobes last one cycle after each write that sets their bit, then drop by themselves
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			align_pulse   <= 1'b0;
			capture_pulse <= 1'b0;
		end else begin
			align_pulse   <= wr_align && req.wdata[align_bit]; // R5 R7
			capture_pulse <= wr_align && req.wdata[capture_bit]; // R7
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			free_counter           <= counter_reset;
			captured_counter_value <= counter_reset;
		end else begin
			free_counter <= free_counter + 12'h001;
			if (wr_align && req.wdata[capture_bit]) begin
				captured_counter_value <= free_counter; // R6 R15
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			pulse_slot_mask <= pulse_slot_reset; // R9
		end else if (wr_mask) begin
			pulse_slot_mask <= req.wdata; // R16
		end
	end

	// A new sample ends the period; access in the same cycle counts for the next one
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			accessed <= 1'b1;
		end else if (output_access) begin
			accessed <= 1'b1;
		end else if (sample_strobe) begin
			accessed <= 1'b0;
		end
	end

	// Set wins over the clear-on-read
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			missed_sample_flag <= 1'b0;
		end else if (missed_event) begin
			missed_sample_flag <= 1'b1; // R10
		end else if (rd_secondary_status) begin
			missed_sample_flag <= 1'b0; // R11
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rsp <= '0;
		end else begin
			rsp.valid <= req.rd_en;
			rsp.data  <= req.rd_en ? read_mux : 16'h0000;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Slot gate

	pulse_slot_gate u_gate (
		.mclk            (mclk),
		.rst_n           (rst_n),
		.pulse_slot_mask (pulse_slot_mask),
		.pwm_pulse_en    (pwm_pulse_en),
		.slot_index      ()
	);

	////////////////////////////////////////////////////////////////////////////////
	// Checks

	a_lock_sets: assert property (@(posedge mclk) disable iff (!rst_n) // R1
		(wr_key && req.wdata == lock_key) |=> config_protected_flag)
		else $error("lock key did not protect");

	a_unlock_clears: assert property (@(posedge mclk) disable iff (!rst_n) // R2
		(wr_key && req.wdata == unlock_key) |=> !config_protected_flag)
		else $error("unlock key did not unprotect");

	a_key_reads_zero: assert property (@(posedge mclk) disable iff (!rst_n) // R3
		(req.rd_en && hit(req, protection_key_addr)) |=> (rsp.valid && rsp.data == 16'h0000))
		else $error("key register read not zero");

	a_align_one_cycle: assert property (@(posedge mclk) disable iff (!rst_n) // R5
		(wr_align && req.wdata[align_bit]) |=> align_pulse)
		else $error("align pulse missing after write");

	a_capture_fires: assert property (@(posedge mclk) disable iff (!rst_n) // R6
		(wr_align && req.wdata[capture_bit]) |=> capture_pulse)
		else $error("capture pulse missing after write");

	// Back-to-back writes may keep a strobe up, so only a quiet cycle must drop it
	a_strobes_drop: assert property (@(posedge mclk) disable iff (!rst_n) // R7
		!wr_align |=> (!align_pulse && !capture_pulse))
		else $error("strobe did not clear itself");

	a_strobe_selfclear: assert property (@(posedge mclk) disable iff (!rst_n) // R7
		(capture_pulse || align_pulse) |-> $past(wr_align))
		else $error("strobe held without a write");

	a_capture_value: assert property (@(posedge mclk) disable iff (!rst_n) // R6
		capture_pulse |-> (captured_counter_value == free_counter - 12'h001))
		else $error("snapshot not taken at write");

	a_locked_mask_hold: assert property (@(posedge mclk) disable iff (!rst_n) // R16
		config_protected_flag && !wr_key |=> $stable(pulse_slot_mask))
		else $error("mask changed while protected");

	a_missed_set: assert property (@(posedge mclk) disable iff (!rst_n) // R10
		missed_event |=> missed_sample_flag)
		else $error("missed sample flag not set");

	a_read_clears: assert property (@(posedge mclk) disable iff (!rst_n) // R11
		(rd_secondary_status && !missed_event) |=> !missed_sample_flag)
		else $error("status read did not clear flag");

	a_status_layout: assert property (@(posedge mclk) disable iff (!rst_n) // R12
		(req.rd_en && hit(req, secondary_status_addr)) |=>
		(rsp.data[2:0] == version && rsp.data[7:4] == 4'h0))
		else $error("status layout wrong");

	a_mask_written: assert property (@(posedge mclk) disable iff (!rst_n) // R16
		wr_mask |=> (pulse_slot_mask == $past(req.wdata)))
		else $error("mask write not taken while unprotected");

	a_protected_read: assert property (@(posedge mclk) disable iff (!rst_n) // R14
		(req.rd_en && hit(req, status_primary_addr)) |=>
		(rsp.data[2] == $past(config_protected_flag)))
		else $error("protected flag not shown in primary status");

endmodule // protect_sync_status_regs

`default_nettype wire

// [pulse_slot_gate.sv]
// Walks the eight input_clock/4 slots and gates the PWM pulse by the slot mask
`timescale 1ns/1ns
`default_nettype none

module pulse_slot_gate
	import protect_sync_pkg::*;
(
	// Clock and reset
	input  wire logic       mclk,
	input  wire logic       rst_n,
	// Slot mask
	input  wire logic [7:0] pulse_slot_mask,
	// Gated pulse enable and current slot
	output var  logic       pwm_pulse_en,
	output var  logic [2:0] slot_index
);

	logic [1:0] div;
	wire        div_wrap = (div == slot_div_last);

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			div          <= 2'h0;
			slot_index   <= 3'h0;
			pwm_pulse_en <= 1'b0;
		end else begin
			div          <= div + 2'h1;
			if (div_wrap) begin
				slot_index <= slot_index + 3'h1;
			end
			pwm_pulse_en <= pulse_slot_mask[slot_index] && (div == 2'h0); // R8
		end
	end

	// Mask is sampled with the slot, so a mask write on that edge cannot upset the check
	a_slot_gated: assert property (@(posedge mclk) disable iff (!rst_n) // R8
		(div == 2'h0 && pulse_slot_mask[slot_index]) |=> pwm_pulse_en)
		else $error("pulse enable missing in enabled slot");

	a_slot_masked: assert property (@(posedge mclk) disable iff (!rst_n) // R8
		(div != 2'h0 || !pulse_slot_mask[slot_index]) |=> !pwm_pulse_en)
		else $error("pulse enable outside an enabled slot");

endmodule // pulse_slot_gate

`default_nettype wire

// [testbench.sv]
// Self-checking testbench for the protect/sync register bank
`timescale 1ns/1ns
`default_nettype none

module testbench
	import protect_sync_pkg::*;
;
	logic        mclk;
	logic        rst_n;
	reg_req_s    req;
	reg_rsp_s    rsp;
	logic        strobe, access, align, capture, prot, missed, pwm;
	logic [7:0]  mask;
	logic [15:0] q, v1;
	logic [7:0]  masks [3] = '{8'h5a, 8'h81, 8'h00};
	int          err_count = 0;
	int          compares = 0;
	int          n;

	protect_sync_status_regs #(.version(3'h5)) dut (.mclk(mclk), .rst_n(rst_n), .req(req),
		.rsp(rsp), .sample_strobe(strobe), .output_access(access), .align_pulse(align),
		.capture_pulse(capture), .config_protected_flag(prot), .missed_sample_flag(missed),
		.pulse_slot_mask(mask), .pwm_pulse_en(pwm));
	meter_host host (.mclk(mclk), .rsp(rsp), .req(req), .sample_strobe(strobe),
		.output_access(access));

	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		host.access(1'b1, a, d, q);
		chk({15'h0, rsp.valid}, 16'h0000);
	endtask

	task automatic rchk(input logic [4:0] a, input logic [15:0] exp);
		host.access(1'b0, a, 8'h00, q);
		chk({15'h0, rsp.valid}, 16'h0001);
		chk(q, exp);
	endtask

	task automatic results;
		$display("compares=%0d err_count=%0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// Whole run is under two hundred cycles; this margin only catches a hang
	initial begin
		repeat (3000) @(posedge mclk);
		err_count++;
		results;
	end

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		rst_n = 1'b0;
		repeat (2) @(negedge mclk);
		rst_n = 1'b1;
		chk({8'h00, mask}, 16'h00ff);
		chk({15'h0, prot}, 16'h0000);
		rchk(pulse_slot_addr, 16'h00ff);
		rchk(secondary_status_addr, 16'h0005);
		$display("test reset done");
		for (int v = 1; v < 4; v++) begin
			wr(align_capture_addr, 8'(v));
			chk({14'h0, capture, align}, 16'(v));
			@(negedge mclk);
			chk({14'h0, capture, align}, 16'h0000);
		end
		wr(align_capture_addr, 8'hfc);
		chk({14'h0, capture, align}, 16'h0000);
		rchk(align_capture_addr, 16'h0000);
		wr(align_capture_addr, 8'h02);
		host.access(1'b0, snapshot_addr, 8'h00, v1);
		wr(align_capture_addr, 8'h02);
		rchk(snapshot_addr, {4'h0, v1[11:0] + 12'h004});
		$display("test align done");
		wr(protection_key_addr, lock_key);
		chk({15'h0, prot}, 16'h0001);
		rchk(protection_key_addr, 16'h0000);
		rchk(status_primary_addr, 16'h0004);
		wr(pulse_slot_addr, 8'h5a);
		chk({8'h00, mask}, 16'h00ff);
		wr(protection_key_addr, 8'h55);
		chk({15'h0, prot}, 16'h0001);
		wr(protection_key_addr, unlock_key);
		chk({15'h0, prot}, 16'h0000);
		rchk(protection_key_addr, 16'h0000);
		$display("test key done");
		// A 32-cycle window covers each slot once, whatever the phase
		foreach (masks[i]) begin
			wr(pulse_slot_addr, masks[i]);
			chk({8'h00, mask}, {8'h00, masks[i]});
			@(negedge mclk);
			n = 0;
			repeat (32) begin
				@(negedge mclk);
				n += int'(pwm);
			end
			chk(16'(n), 16'($countones(masks[i])));
		end
		$display("test slots done");
		host.timing(1'b1, 1'b0);
		host.timing(1'b0, 1'b1);
		host.timing(1'b1, 1'b0);
		@(negedge mclk);
		chk({15'h0, missed}, 16'h0000);
		host.timing(1'b1, 1'b0);
		@(negedge mclk);
		chk({15'h0, missed}, 16'h0001);
		rchk(secondary_status_addr, 16'h000d);
		chk({15'h0, missed}, 16'h0000);
		rchk(secondary_status_addr, 16'h0005);
		rchk(5'h1f, 16'h0000);
		$display("test missed done");
		results;
	end
endmodule // testbench

`default_nettype wire
